// file: shared/brcs_pkg.sv
// register map, field layout and timing for the regulator control/status bank
`default_nettype none
package brcs_pkg;
  // register offsets on the internal register port
  localparam logic [7:0] CEIL_ADDR = 8'h03;
  localparam logic [7:0] LIMIT_ADDR = 8'h04;
  localparam logic [7:0] FLAGS_ADDR = 8'h05;
  // reset values
  localparam logic [7:0] CEIL_RESET = 8'h11;
  localparam logic [7:0] LIMIT_RESET = 8'h1D;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // field positions
  localparam int CEIL_CODE_MSB = 4;
  localparam int LIMIT_OFF_BIT = 5;
  localparam int SOFT_CAP_BIT = 4;
  localparam int LIMIT_CODE_MSB = 3;
  localparam int THERMAL_BIT = 7;
  localparam int DIE_HOT_BIT = 6;
  localparam int SCHEME_BIT = 5;
  localparam int PATH_BIT = 4;
  localparam int BYPASS_OC_BIT = 3;
  localparam int BOOST_OC_BIT = 2;
  localparam int FAULT_BIT = 1;
  localparam int REGULATION_BIT = 0;
  // mode-control enable field code for forced pass-through
  localparam logic [1:0] FORCED_PASS_CODE = 2'h2;
  // boost input limit must persist this long before its flag latches
  localparam int CLK_MHZ = 100;
  localparam int BOOST_LIMIT_TIME_US = 1500;
  localparam int BOOST_LIMIT_CYCLES = BOOST_LIMIT_TIME_US * CLK_MHZ;

  // one access from the serial slave engine
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } brcs_req_s;

  // asynchronous indications from the analog converter and pins
  typedef struct packed {
    logic thermalTrip;
    logic dieHot;
    logic pwmActive;
    logic dcdcActive;
    logic bypassLimit;
    logic boostInputLimit;
    logic faultEvent;
    logic outputInRegulation;
    logic enablePin;
  } brcs_sense_s;
endpackage
`default_nettype wire

// file: hw/brcs_regs.sv
// ceiling, current-limit and status registers of the boost/bypass regulator
// What this block does
// - five-bit output ceiling code, 2.85V to 4.4V in 0.05V steps, reset 10001
// - limit register bit five: zero keeps current limit, one disables it
// - limit register bit four selects soft-start cap, resets to one
// - limit code in bits three to zero, 1500mA to 5000mA, reset 1101
// - status bit seven latches thermal shutdown, cleared by a status read
// - status bit six is live die-hot indication
// - status bit five shows switching scheme, one for pulse-width
// - status bit four shows path, one for active conversion
// - status bit three latches bypass overcurrent, cleared by status read
// - status bit two latches after boost input limit persists 1.5ms during active conversion
// - status bit one latches any fault, cleared by status read
// - status bit zero shows regulation, forced one during forced pass-through
// - enable field code 10 forces pass-through while the enable pin is high
`timescale 1ns/10ps
`default_nettype none
module brcs_regs #(
  parameter int unsigned BoostLimitCycles = brcs_pkg::BOOST_LIMIT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port from the serial slave engine
  input wire brcs_pkg::brcs_req_s regReq,
  output logic [7:0] rdData,
  output logic rdValid,
  // mode-control enable field, same clock domain
  input wire logic [1:0] enableField,
  // converter indications, asynchronous
  input wire brcs_pkg::brcs_sense_s sense,
  // controls to the converter
  output logic [4:0] ceilingCode,
  output logic currentLimitOff,
  output logic softStartCap,
  output logic [3:0] currentLimitCode,
  output logic forcedPassThrough
);
  import brcs_pkg::*;

  localparam int CW = $clog2(BoostLimitCycles + 1);
  localparam logic [CW-1:0] LAST_COUNT = CW'(BoostLimitCycles - 1);

  brcs_sense_s senseS1;
  brcs_sense_s senseS2;
  logic [7:0] ceil_q;
  logic [7:0] ceil_d;
  logic [7:0] limit_q;
  logic [7:0] limit_d;
  logic thermalFlag_q;
  logic bypassFlag_q;
  logic boostFlag_q;
  logic faultFlag_q;
  logic [CW-1:0] boostCnt_q;
  logic [CW-1:0] boostCnt_d;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic rdValid_q;
  logic forced_q;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      senseS1 <= '0;
      senseS2 <= '0;
    end else begin
      senseS1 <= sense;
      senseS2 <= senseS1;
    end
  end

  // decode
  wire ceilWr = regReq.wr && (regReq.addr == CEIL_ADDR);
  wire limitWr = regReq.wr && (regReq.addr == LIMIT_ADDR);
  wire flagsRd = regReq.rd && (regReq.addr == FLAGS_ADDR);
  wire ceilRd = regReq.rd && (regReq.addr == CEIL_ADDR);
  wire limitRd = regReq.rd && (regReq.addr == LIMIT_ADDR);

  // whole byte stored, so reserved bits read back but drive nothing
  assign ceil_d = ceilWr ? regReq.wdata : ceil_q;
  assign limit_d = limitWr ? regReq.wdata : limit_q;

  // forced pass-through overrides the bypass pin only while enabled
  wire forcedPass = senseS2.enablePin && (enableField == FORCED_PASS_CODE);

  // boost input limit must hold continuously during conversion
  wire boostCond = senseS2.boostInputLimit && senseS2.dcdcActive;
  wire boostHeld = boostCond && (boostCnt_q == LAST_COUNT);
  assign boostCnt_d = !boostCond ? '0 :
                      boostHeld ? boostCnt_q : boostCnt_q + 1'b1;

  wire regulationView = senseS2.outputInRegulation || forced_q;
  wire [7:0] flagsView = {thermalFlag_q, senseS2.dieHot, senseS2.pwmActive,
                          senseS2.dcdcActive, bypassFlag_q, boostFlag_q,
                          faultFlag_q, regulationView};

  // clear only what this read returns; a same-cycle event wins
  wire clrThermal = flagsRd && flagsView[THERMAL_BIT];
  wire clrBypass = flagsRd && flagsView[BYPASS_OC_BIT];
  wire clrBoost = flagsRd && flagsView[BOOST_OC_BIT];
  wire clrFault = flagsRd && flagsView[FAULT_BIT];

  assign rdData_d = flagsRd ? flagsView :
                    ceilRd ? ceil_q :
                    limitRd ? limit_q : UNMAPPED_DATA;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ceil_q <= CEIL_RESET;
      limit_q <= LIMIT_RESET;
    end else begin
      ceil_q <= ceil_d;
      limit_q <= limit_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      thermalFlag_q <= FLAGS_RESET[THERMAL_BIT];
      bypassFlag_q <= FLAGS_RESET[BYPASS_OC_BIT];
      boostFlag_q <= FLAGS_RESET[BOOST_OC_BIT];
      faultFlag_q <= FLAGS_RESET[FAULT_BIT];
    end else begin
      thermalFlag_q <= senseS2.thermalTrip || (thermalFlag_q && !clrThermal);
      bypassFlag_q <= senseS2.bypassLimit || (bypassFlag_q && !clrBypass);
      boostFlag_q <= boostHeld || (boostFlag_q && !clrBoost);
      faultFlag_q <= senseS2.faultEvent || (faultFlag_q && !clrFault);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      boostCnt_q <= '0;
      rdData_q <= UNMAPPED_DATA;
      rdValid_q <= 1'b0;
      forced_q <= 1'b0;
    end else begin
      boostCnt_q <= boostCnt_d;
      rdData_q <= rdData_d;
      rdValid_q <= regReq.rd;
      forced_q <= forcedPass;
    end
  end

  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign ceilingCode = ceil_q[CEIL_CODE_MSB:0];
  assign currentLimitOff = limit_q[LIMIT_OFF_BIT];
  assign softStartCap = limit_q[SOFT_CAP_BIT];
  assign currentLimitCode = limit_q[LIMIT_CODE_MSB:0];
  assign forcedPassThrough = forced_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  ceiling_write_a: assert property (ceilWr |=> ceilingCode == $past(regReq.wdata[4:0]))
    else $error("ceiling code did not take write");
  limit_fields_a: assert property (limitWr |=>
    {currentLimitOff, softStartCap, currentLimitCode} == $past(regReq.wdata[5:0]))
    else $error("limit fields did not take write");
  reserved_echo_a: assert property (ceilWr ##1 !ceilWr ##1 (ceilRd && !ceilWr) |=>
    rdData == $past(regReq.wdata, 3))
    else $error("reserved bits not read back");
  thermal_latch_a: assert property (senseS2.thermalTrip |=> thermalFlag_q)
    else $error("thermal flag missed");
  thermal_clear_a: assert property (flagsRd && !senseS2.thermalTrip |=>
    !thermalFlag_q ##1 !rdData[THERMAL_BIT] || !flagsRd)
    else $error("thermal flag not cleared by read");
  bypass_keep_a: assert property (flagsRd && senseS2.bypassLimit |=> bypassFlag_q)
    else $error("event lost during read");
  fault_clear_a: assert property (flagsRd && !senseS2.faultEvent |=> !faultFlag_q)
    else $error("fault flag not cleared by read");
  bypass_latch_a: assert property (senseS2.bypassLimit |=> bypassFlag_q)
    else $error("bypass overcurrent flag missed");
  boost_cause_a: assert property ($rose(boostFlag_q) |-> $past(boostHeld))
    else $error("boost flag set before persistence time");
  boost_count_a: assert property (boostCond && (boostCnt_q != LAST_COUNT) |=>
    boostCnt_q == $past(boostCnt_q) + 1'b1)
    else $error("boost count off");
  forced_good_a: assert property (forced_q && flagsRd |=> rdData[REGULATION_BIT])
    else $error("regulation bit not forced");
  live_read_a: assert property (flagsRd |=>
    rdData[7:4] == {$past(thermalFlag_q), $past(senseS2.dieHot),
                    $past(senseS2.pwmActive), $past(senseS2.dcdcActive)})
    else $error("live status bits wrong");
  forced_code_a: assert property (forcedPassThrough |->
    $past(enableField) == FORCED_PASS_CODE && $past(senseS2.enablePin))
    else $error("forced pass-through without code");

  // control registers keep their byte between writes
  ceil_hold_a: assert property (!ceilWr |=>
    ceil_q == $past(ceil_q))
    else $error("ceiling register changed without write");
  limit_hold_a: assert property (!limitWr |=>
    limit_q == $past(limit_q))
    else $error("limit register changed without write");
  ceil_byte_a: assert property (ceilWr |=>
    ceil_q == $past(regReq.wdata))
    else $error("ceiling byte not stored");
  limit_byte_a: assert property (limitWr |=>
    limit_q == $past(regReq.wdata))
    else $error("limit byte not stored");
  ceil_reserved_a: assert property (ceilWr |=>
    ceil_q[7:5] == $past(regReq.wdata[7:5]))
    else $error("ceiling reserved bits not stored");
  limit_reserved_a: assert property (limitWr |=>
    limit_q[7:6] == $past(regReq.wdata[7:6]))
    else $error("limit reserved bits not stored");

  // each limit field follows its own bit of the write
  limit_off_a: assert property (limitWr |=>
    currentLimitOff == $past(regReq.wdata[LIMIT_OFF_BIT]))
    else $error("limit disable bit wrong");
  soft_cap_a: assert property (limitWr |=>
    softStartCap == $past(regReq.wdata[SOFT_CAP_BIT]))
    else $error("soft-start cap bit wrong");
  limit_code_a: assert property (limitWr |=>
    currentLimitCode == $past(regReq.wdata[LIMIT_CODE_MSB:0]))
    else $error("limit code wrong");

  // read data is only valid the cycle after the strobe
  ceil_read_a: assert property (ceilRd |=>
    rdData == $past(ceil_q))
    else $error("ceiling read data wrong");
  limit_read_a: assert property (limitRd |=>
    rdData == $past(limit_q))
    else $error("limit read data wrong");

  // sticky flags survive until a status read
  thermal_keep_a: assert property (thermalFlag_q && !flagsRd |=>
    thermalFlag_q)
    else $error("thermal flag dropped without read");
  bypass_hold_a: assert property (bypassFlag_q && !flagsRd |=>
    bypassFlag_q)
    else $error("bypass flag dropped without read");
  boost_hold_a: assert property (boostFlag_q && !flagsRd |=>
    boostFlag_q)
    else $error("boost flag dropped without read");
  fault_hold_a: assert property (faultFlag_q && !flagsRd |=>
    faultFlag_q)
    else $error("fault flag dropped without read");

  // a read with the cause gone clears the flag; a cause sets it; a break in the condition restarts the boost count
  bypass_clear_a: assert property (flagsRd && !senseS2.bypassLimit |=>
    !bypassFlag_q)
    else $error("bypass flag not cleared by read");
  boost_clear_a: assert property (flagsRd && !boostHeld |=>
    !boostFlag_q)
    else $error("boost flag not cleared by read");
  fault_latch_a: assert property (senseS2.faultEvent |=>
    faultFlag_q)
    else $error("fault flag missed");
  boost_set_a: assert property (boostHeld |=>
    boostFlag_q)
    else $error("boost flag missed after persistence");
  boost_reset_a: assert property (!boostCond |=>
    boostCnt_q == '0)
    else $error("boost count not restarted");

  // an event in the read cycle must win over the clear
  thermal_race_a: assert property (flagsRd && senseS2.thermalTrip |=>
    thermalFlag_q)
    else $error("thermal event lost during read");
  fault_race_a: assert property (flagsRd && senseS2.faultEvent |=>
    faultFlag_q)
    else $error("fault event lost during read");
  boost_race_a: assert property (flagsRd && boostHeld |=>
    boostFlag_q)
    else $error("boost event lost during read");

  // status byte fields, live and sticky
  die_live_a: assert property (flagsRd |=>
    rdData[DIE_HOT_BIT] == $past(senseS2.dieHot))
    else $error("die-hot bit wrong");
  scheme_live_a: assert property (flagsRd |=>
    rdData[SCHEME_BIT] == $past(senseS2.pwmActive))
    else $error("switching scheme bit wrong");
  path_live_a: assert property (flagsRd |=>
    rdData[PATH_BIT] == $past(senseS2.dcdcActive))
    else $error("operating path bit wrong");
  regulation_live_a: assert property (flagsRd && !forced_q |=>
    rdData[REGULATION_BIT] == $past(senseS2.outputInRegulation))
    else $error("regulation bit wrong");
  sticky_read_a: assert property (flagsRd |=>
    rdData[3:1] == $past({bypassFlag_q, boostFlag_q, faultFlag_q}))
    else $error("sticky status bits wrong");

  // forcing needs both the pin and the field code
  forced_off_a: assert property (!senseS2.enablePin |=>
    !forcedPassThrough)
    else $error("forced pass-through without enable pin");
  forced_on_a: assert property (forcedPass |=>
    forcedPassThrough)
    else $error("forced pass-through not applied");


  thermal_read_c: cover property (thermalFlag_q ##1 flagsRd ##1 !thermalFlag_q);
  boost_set_c: cover property ($rose(boostFlag_q));
  forced_pass_c: cover property (forcedPassThrough && flagsRd);
  race_keep_c: cover property (flagsRd && senseS2.bypassLimit && bypassFlag_q);
  limit_write_c: cover property (limitWr);
endmodule // brcs_regs
`default_nettype wire

// file: bench/brcs_host.sv
// host model issuing single-byte register accesses to the regulator bank
`timescale 1ns/10ps
`default_nettype none
module brcs_host (
  // clock
  input wire logic mclk,
  // register port
  output var brcs_pkg::brcs_req_s regReq,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  import brcs_pkg::*;
  initial regReq = '0;
  // strobes last one cycle; stale data is inverted so nothing leans on it
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge mclk);
    regReq <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    regReq.wr <= 1'b0;
    regReq.wdata <= ~dat;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic vld);
    @(posedge mclk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    regReq.rd <= 1'b0;
    #1;
    dat = rdData;
    vld = rdValid;
  endtask
endmodule // brcs_host
`default_nettype wire

// file: bench/tb_boost_regulator_ctrl_status_regs.sv
// self-checking bench for the regulator control/status bank
`timescale 1ns/10ps
`default_nettype none
module tb_boost_regulator_ctrl_status_regs;
  import brcs_pkg::*;
  // short boost persistence so the run stays brief
  localparam int Cyc = 8;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] enableField = 2'h0;
  brcs_sense_s sense = '0;
  brcs_req_s regReq;
  logic [7:0] rdData;
  logic rdValid;
  logic [4:0] ceilingCode;
  logic currentLimitOff;
  logic softStartCap;
  logic [3:0] currentLimitCode;
  logic forcedPassThrough;
  logic [7:0] d;
  logic v;
  logic [7:0] ceil;
  logic [7:0] lim;
  integer seed = 32'hA5F5;
  int error_cnt = 0;
  int num_checks = 0;
  brcs_regs #(.BoostLimitCycles(Cyc)) i_brcs_regs (.mclk(mclk), .nrst(nrst), .regReq(regReq),
    .rdData(rdData), .rdValid(rdValid), .enableField(enableField), .sense(sense),
    .ceilingCode(ceilingCode), .currentLimitOff(currentLimitOff), .softStartCap(softStartCap),
    .currentLimitCode(currentLimitCode), .forcedPassThrough(forcedPassThrough));
  brcs_host i_brcs_host (.mclk(mclk), .regReq(regReq), .rdData(rdData), .rdValid(rdValid));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_brcs_host.rd(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // live status bits straight from the sense levels
  function automatic logic [7:0] live(input brcs_sense_s s);
    return {1'b0, s.dieHot, s.pwmActive, s.dcdcActive, 3'h0, s.outputInRegulation};
  endfunction
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    rdchk(CEIL_ADDR, CEIL_RESET);
    rdchk(LIMIT_ADDR, LIMIT_RESET);
    rdchk(FLAGS_ADDR, FLAGS_RESET);
    rdchk(8'h06, UNMAPPED_DATA);
    check({2'h0, currentLimitOff, softStartCap, currentLimitCode}, LIMIT_RESET);
    for (int i = 0; i < 8; i++) begin
      ceil = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      lim = (i == 0) ? 8'hFF : (i == 1) ? 8'hC8 : 8'($random(seed));
      @(posedge mclk) sense <= 9'($random(seed)) & 9'h0E2;
      i_brcs_host.wr(CEIL_ADDR, ceil);
      i_brcs_host.wr(LIMIT_ADDR, lim);
      i_brcs_host.wr(FLAGS_ADDR, 8'hFF);
      rdchk(CEIL_ADDR, ceil);
      rdchk(LIMIT_ADDR, lim);
      check({3'h0, ceilingCode}, {3'h0, ceil[4:0]});
      check({2'h0, currentLimitOff, softStartCap, currentLimitCode}, {2'h0, lim[5:0]});
      rdchk(FLAGS_ADDR, live(sense));
    end
    @(posedge mclk) sense <= 9'h114;
    repeat (2) @(posedge mclk);
    sense <= '0;
    repeat (4) @(posedge mclk);
    rdchk(FLAGS_ADDR, 8'h8A);
    rdchk(FLAGS_ADDR, 8'h00);
    @(posedge mclk) sense <= 9'h010;
    repeat (4) @(posedge mclk);
    rdchk(FLAGS_ADDR, 8'h08);
    @(posedge mclk) sense <= '0;
    repeat (4) @(posedge mclk);
    rdchk(FLAGS_ADDR, 8'h08);
    rdchk(FLAGS_ADDR, 8'h00);
    // limit alone, then a boost episode too short, then one long enough
    @(posedge mclk) sense <= 9'h008;
    repeat (Cyc + 4) @(posedge mclk);
    sense <= 9'h028;
    repeat (Cyc - 2) @(posedge mclk);
    sense <= 9'h020;
    repeat (4) @(posedge mclk);
    rdchk(FLAGS_ADDR, 8'h10);
    @(posedge mclk) sense <= 9'h028;
    repeat (Cyc + 4) @(posedge mclk);
    sense <= 9'h020;
    repeat (4) @(posedge mclk);
    rdchk(FLAGS_ADDR, 8'h14);
    @(posedge mclk) sense <= 9'h001;
    enableField <= FORCED_PASS_CODE;
    repeat (5) @(posedge mclk);
    check({7'h00, forcedPassThrough}, 8'h01);
    rdchk(FLAGS_ADDR, 8'h01);
    @(posedge mclk) sense <= '0;
    repeat (5) @(posedge mclk);
    check({7'h00, forcedPassThrough}, 8'h00);
    rdchk(FLAGS_ADDR, 8'h00);
    conclude();
  end
endmodule // tb_boost_regulator_ctrl_status_regs
`default_nettype wire
